//--- bench/cdrb_host.sv
/*
 Serial host model: 24 bit frames, MSB first, link clock idles low.
 Assumes the core clock paces it; pins move on its falling edge.
*/
`timescale 1ns/1ps
module cdrb_host (
   // pacing
   input wire clk,
   // link
   output reg sclk = 1'b0,
   output reg sdin = 1'b0,
   output reg latch = 1'b0,
   input wire sdout
);
   reg [23:0] rd = 24'h00_0000;
   task idle(input integer n);
      repeat (n) @(negedge clk);
   endtask
   // word of the previous read lands in rd; first sample drops out
   task frame(input [7:0] cmd, input [15:0] data);
      integer i;
      for (i = 0; i < 24; i = i + 1) begin
         sdin = cmd_data_bit(cmd, data, i);
         idle(4);
         rd = {rd[22:0], sdout};
         sclk = 1'b1;
         idle(4);
         sclk = 1'b0;
      end
      idle(4);
      rd = {rd[22:0], sdout};
      // released data line must not keep its last level
      sdin = ~sdin;
      latch = 1'b1;
      idle(4);
      latch = 1'b0;
      idle(2);
   endtask
   function cmd_data_bit(input [7:0] c, input [15:0] d, input integer i);
      reg [23:0] w;
      w = {c, d};
      return w[23 - i];
   endfunction
endmodule

//--- bench/cdrb_register_bank_chk.sv
/*
 Port checker for the register bank, bound below.
 Assumes outputs move only after a latch edge or during a ramp.
*/
`timescale 1ns/1ps
module cdrb_register_bank_chk #(
   parameter CODE_BITS = 16,
   parameter [2:0] LOOP_RANGE_CODE = 3'h5
) (
   // clock, reset, link
   input wire CORE_CLK,
   input wire NRST,
   input wire SERIAL_CLK,
   input wire SERIAL_DIN,
   input wire SERIAL_LATCH,
   input wire SERIAL_DOUT,
   // monitors
   input wire FRAME_CHECK_FAIL,
   input wire TIMEOUT_EXPIRED,
   input wire LOAD_FAULT,
   input wire DIE_OVERTEMP,
   // output path
   input wire [15:0] OUTPUT_CODE,
   input wire [2:0] OUTPUT_RANGE,
   input wire OUTPUT_DRIVE_ENABLE,
   input wire EXTERNAL_RESISTOR_SELECT,
   input wire MODEM_COUPLING_ENABLE,
   input wire FRAME_CHECK_ENABLE,
   input wire TIMEOUT_MONITOR_ENABLE,
   input wire [1:0] TIMEOUT_PERIOD_SELECT,
   input wire TIMEOUT_SERVICE,
   input wire RAMP_ACTIVE_FLAG
);
   localparam int WIN = 12;
   reg latch_q;
   reg [3:0] since_lat;
   // raw pin sampled; the window absorbs the synchroniser delay
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         latch_q <= 1'b0;
         since_lat <= 4'hF;
      end else begin
         latch_q <= SERIAL_LATCH;
         if (SERIAL_LATCH && !latch_q)
            since_lat <= 4'h0;
         else if (since_lat != 4'hF)
            since_lat <= since_lat + 4'h1;
      end
   end
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!NRST);
   sequence fresh;
      since_lat <= WIN;
   endsequence
   sequence jump_s;
      $changed(OUTPUT_CODE) && !RAMP_ACTIVE_FLAG
         && !$past(RAMP_ACTIVE_FLAG);
   endsequence
   sequence slew_s;
      $changed(OUTPUT_CODE) && RAMP_ACTIVE_FLAG;
   endsequence
   range_upd_a: assert property ($changed(OUTPUT_RANGE) |-> fresh)
      else $error("range moved without a frame");
   drive_upd_a: assert property ($changed(OUTPUT_DRIVE_ENABLE) |-> fresh)
      else $error("drive enable moved without a frame");
   feat_upd_a: assert property ($changed({FRAME_CHECK_ENABLE,
      TIMEOUT_MONITOR_ENABLE, TIMEOUT_PERIOD_SELECT}) |-> fresh)
      else $error("feature pins moved without a frame");
   modem_range_a: assert property (MODEM_COUPLING_ENABLE |->
      OUTPUT_RANGE == LOOP_RANGE_CODE ||
      $past(OUTPUT_RANGE) == LOOP_RANGE_CODE)
      else $error("modem coupled outside loop range");
   svc_pulse_a: assert property (TIMEOUT_SERVICE |->
      fresh ##1 !TIMEOUT_SERVICE)
      else $error("service pulse too long or unasked");
   code_jump_a: assert property (jump_s |-> fresh)
      else $error("code jumped without a frame");
   ramp_hold_a: assert property (slew_s |=> $stable(OUTPUT_CODE)[*8])
      else $error("ramp stepped too fast");
   ramp_rise_a: assert property ($rose(RAMP_ACTIVE_FLAG) |-> fresh)
      else $error("ramp flag rose without a frame");
endmodule
bind cdrb_register_bank cdrb_register_bank_chk #(
   .CODE_BITS(CODE_BITS), .LOOP_RANGE_CODE(LOOP_RANGE_CODE)
) i_cdrb_register_bank_chk (
   .CORE_CLK, .NRST, .SERIAL_CLK, .SERIAL_DIN, .SERIAL_LATCH, .SERIAL_DOUT,
   .FRAME_CHECK_FAIL, .TIMEOUT_EXPIRED, .LOAD_FAULT, .DIE_OVERTEMP,
   .OUTPUT_CODE, .OUTPUT_RANGE, .OUTPUT_DRIVE_ENABLE,
   .EXTERNAL_RESISTOR_SELECT, .MODEM_COUPLING_ENABLE, .FRAME_CHECK_ENABLE,
   .TIMEOUT_MONITOR_ENABLE, .TIMEOUT_PERIOD_SELECT, .TIMEOUT_SERVICE,
   .RAMP_ACTIVE_FLAG
);

//--- bench/current_dac_register_bank_tb_top.sv
/*
 Bench: register model checked against readback and output pins.
 Assumes cdrb_host drives the link and the bound checker is present.
*/
`timescale 1ns/1ps
module current_dac_register_bank_tb_top;
   reg clk = 0, nrst = 0, fail_p = 0, tmo_p = 0, load_f = 0, hot = 0;
   wire sclk, sdin, latch, sdout, drv, ext, modem, fchk, timeout_monitor_enable, svc, ramp;
   wire [15:0] code_o;
   wire [2:0] range;
   wire [1:0] wdsel;
   integer n_fail = 0, comparisons = 0, svc_n = 0, k, j;
   reg [15:0] ctrl = 0, cfg = 0, code = 0, gain = 0, zero = 0, st = 0;
   always #10 clk = ~clk;
   always @(posedge clk) if (svc === 1'b1) svc_n <= svc_n + 1;
   cdrb_register_bank i_cdrb_register_bank (.CORE_CLK(clk), .NRST(nrst),
      .SERIAL_CLK(sclk), .SERIAL_DIN(sdin), .SERIAL_LATCH(latch),
      .SERIAL_DOUT(sdout), .FRAME_CHECK_FAIL(fail_p),
      .TIMEOUT_EXPIRED(tmo_p), .LOAD_FAULT(load_f), .DIE_OVERTEMP(hot),
      .OUTPUT_CODE(code_o), .OUTPUT_RANGE(range), .OUTPUT_DRIVE_ENABLE(drv),
      .EXTERNAL_RESISTOR_SELECT(ext), .MODEM_COUPLING_ENABLE(modem),
      .FRAME_CHECK_ENABLE(fchk), .TIMEOUT_MONITOR_ENABLE(timeout_monitor_enable),
      .TIMEOUT_PERIOD_SELECT(wdsel), .TIMEOUT_SERVICE(svc),
      .RAMP_ACTIVE_FLAG(ramp));
   cdrb_host i_cdrb_host (.clk(clk), .sclk(sclk), .sdin(sdin),
      .latch(latch), .sdout(sdout));
   task chk(input [23:0] got, input [23:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input [7:0] cmd, input [15:0] data);
      i_cdrb_host.frame(cmd, data);
      repeat (12) @(negedge clk);
   endtask
   task rd(input [5:0] sel, input [15:0] exp);
      i_cdrb_host.frame(8'h02, {10'h000, sel});
      i_cdrb_host.frame(8'h00, 16'h0000);
      chk(i_cdrb_host.rd, {8'h00, exp});
   endtask
   function [15:0] trimmed(input [15:0] c);
      longint v, z;
      v = c;
      // signed offset must not be zero-extended by unsigned operands
      z = $signed(zero);
      if (cfg[5])
         v = ((v * (65536 - longint'(gain))) >>> 16) + z;
      return v < 0 ? 16'h0000 : (v > 65535 ? 16'hFFFF : v[15:0]);
   endfunction
   task pins;
      chk(code_o, trimmed(code));
      chk(range, ctrl[2:0]);
      chk(ext, ctrl[13]);
      chk(drv, ctrl[12]);
      chk(modem, cfg[4] && ctrl[2:0] == 3'h5);
      chk({fchk, timeout_monitor_enable, wdsel}, cfg[3:0]);
   endtask
   task readall;
      rd(6'h00, st);
      rd(6'h01, code);
      rd(6'h02, ctrl);
      rd(6'h0B, cfg);
      rd(6'h13, gain);
      rd(6'h17, zero);
   endtask
   task wrap_up;
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      k = $urandom(32'hc4ec);
      repeat (5) @(negedge clk);
      nrst = 1;
      repeat (3) @(negedge clk);
      readall();
      pins();
      for (j = 0; j < 3; j = j + 1) begin
         ctrl = $urandom & 16'h3FE7;
         cfg = $urandom & 16'h001F;
         if (j == 2) begin
            ctrl[2:0] = 3'h5;
            cfg[4] = 1'b1;
         end
         wr(8'h55, ctrl);
         wr(8'h57, cfg);
         pins();
      end
      code = $urandom;
      wr(8'h01, code);
      pins();
      for (j = 0; j < 2; j = j + 1) begin
         gain = $urandom;
         zero = j ? 16'h7FFF : 16'h8000;
         code = j ? 16'hFF00 : 16'h0100;
         cfg = 16'h0020;
         wr(8'h58, gain);
         wr(8'h59, zero);
         wr(8'h57, cfg);
         wr(8'h01, code);
         pins();
      end
      readall();
      // slow ramp of 32 unit steps so status can be read mid-way
      cfg = 0;
      ctrl = 16'h0010;
      wr(8'h57, cfg);
      wr(8'h55, ctrl);
      code = 16'hFEE0;
      i_cdrb_host.frame(8'h01, code);
      repeat (4) @(negedge clk);
      chk(ramp, 1);
      rd(6'h00, 16'h0002);
      for (k = 0; k < 3000 && ramp !== 1'b0; k = k + 1)
         @(negedge clk);
      chk(ramp, 0);
      if (k == 3000)
         wrap_up();
      pins();
      cfg = 16'h000C;
      wr(8'h57, cfg);
      {fail_p, tmo_p, load_f, hot} = 4'hF;
      @(negedge clk);
      {fail_p, tmo_p} = 2'h0;
      st = 16'h001D;
      rd(6'h00, st);
      wr(8'h96, 16'h0000);
      k = svc_n;
      wr(8'h95, 16'h0000);
      chk(svc_n - k, 1);
      load_f = 0;
      st = 16'h0001;
      rd(6'h00, st);
      cfg = 16'h0004;
      wr(8'h57, cfg);
      {fail_p, tmo_p} = 2'h3;
      @(negedge clk);
      {fail_p, tmo_p, hot} = 3'h0;
      st = 16'h0008;
      readall();
      wr(8'h56, 16'hFFFE);
      readall();
      wr(8'h56, 16'h0001);
      {ctrl, cfg, code, gain, zero, st} = 0;
      readall();
      pins();
      wrap_up();
   end
endmodule

//--- src/cdrb_defs.vh
/*
 Constants for the current output register bank: command codes, read
 selectors, field positions, reset values and timing counts.
 Assumes it is included by bare name in the bank's design file.
*/
`ifndef CDRB_DEFS_VH
`define CDRB_DEFS_VH
// command codes in the address byte
`define CDRB_CMD_NOP 8'h00
`define CDRB_CMD_CODE 8'h01
`define CDRB_CMD_READ 8'h02
`define CDRB_CMD_CTRL 8'h55
`define CDRB_CMD_RESET 8'h56
`define CDRB_CMD_CONFIG 8'h57
`define CDRB_CMD_GAIN 8'h58
`define CDRB_CMD_ZERO 8'h59
`define CDRB_CMD_WD_SERVICE 8'h95
`define CDRB_CMD_CRC_CLEAR 8'h96
// read selectors
`define CDRB_RD_STATUS 2'h0
`define CDRB_RD_CODE 2'h1
`define CDRB_RD_CTRL 2'h2
`define CDRB_RD_CONFIG 6'h0B
`define CDRB_RD_GAIN 6'h13
`define CDRB_RD_ZERO 6'h17
// output control fields
`define CDRB_CTRL_EXTRES 13
`define CDRB_CTRL_OUTPUT_DRIVE_ENABLE 12
`define CDRB_CTRL_RCLK_HI 11
`define CDRB_CTRL_RCLK_LO 8
`define CDRB_CTRL_RSTEP_HI 7
`define CDRB_CTRL_RSTEP_LO 5
`define CDRB_CTRL_RAMPEN 4
`define CDRB_CTRL_MASK 16'h3FF7
// feature config fields
`define CDRB_CFG_TRIM 5
`define CDRB_CFG_MODEM 4
`define CDRB_CFG_FCHK 3
`define CDRB_CFG_TIMEOUT_MONITOR_ENABLE 2
`define CDRB_CFG_MASK 16'h003F
// status fields
`define CDRB_ST_FRAME 4
`define CDRB_ST_TIMEOUT 3
`define CDRB_ST_LOAD 2
`define CDRB_ST_RAMP 1
`define CDRB_ST_TEMP 0
// reset values
`define CDRB_RST_WORD 16'h0000
// frame and ramp timing
`define CDRB_FRAME_BITS 24
`define CDRB_RAMP_BASE_NS 1000
`define CDRB_CLK_NS 20
`endif

//--- src/cdrb_register_bank.v
/*
 Register bank of a single channel current output converter, reached
 over the three wire serial frame (clock, data in, latch) with a data
 out line for register reads. Holds control, config, code and trim
 words, the soft reset command and the fault status word, and drives
 the calibrated and ramped output code.
 Assumes serial pins, load fault and overtemp levels are asynchronous;
 frame error and watchdog expiry pulses come from core clock logic.
*/
`timescale 1ns/1ps
`include "cdrb_defs.vh"

module cdrb_register_bank #(
   parameter CODE_BITS = 16,
   parameter [2:0] LOOP_RANGE_CODE = 3'h5
) (
   // clock and reset
   input wire CORE_CLK,
   input wire NRST,
   // serial link
   input wire SERIAL_CLK,
   input wire SERIAL_DIN,
   input wire SERIAL_LATCH,
   output reg SERIAL_DOUT,
   // monitors
   input wire FRAME_CHECK_FAIL,
   input wire TIMEOUT_EXPIRED,
   input wire LOAD_FAULT,
   input wire DIE_OVERTEMP,
   // output path
   output reg [15:0] OUTPUT_CODE,
   output reg [2:0] OUTPUT_RANGE,
   output reg OUTPUT_DRIVE_ENABLE,
   output reg EXTERNAL_RESISTOR_SELECT,
   output reg MODEM_COUPLING_ENABLE,
   // feature controls
   output reg FRAME_CHECK_ENABLE,
   output reg TIMEOUT_MONITOR_ENABLE,
   output reg [1:0] TIMEOUT_PERIOD_SELECT,
   output reg TIMEOUT_SERVICE,
   output reg RAMP_ACTIVE_FLAG
);

   localparam RAMP_BASE_CYC = (`CDRB_RAMP_BASE_NS + `CDRB_CLK_NS - 1) /
      `CDRB_CLK_NS;
   localparam [15:0] CODE_KEEP = ~((16'h0001 << (16 - CODE_BITS)) -
      16'h0001);

   // keeps only the bits the narrow variant really has
   function [15:0] keep_code;
      input [15:0] w;
      begin
         keep_code = w & CODE_KEEP;
      end
   endfunction

   // synchronisers: stage one read only by stage two
   reg [4:0] sync_a;
   reg [4:0] sync_b;
   reg sclk_d;
   reg latch_d;

   reg [23:0] shift_in;
   reg [23:0] shift_out;
   reg read_pending;
   reg [5:0] read_sel;

   reg [15:0] output_control;
   reg [15:0] feature_config;
   reg [15:0] output_code;
   reg [15:0] gain_trim;
   reg [15:0] offset_trim;
   reg frame_error_flag;
   reg timeout_flag;
   reg load_fault_flag;
   reg overtemp_flag;
   reg soft_reset;

   reg [15:0] target_code;
   reg [15:0] ramp_code;
   reg [23:0] ramp_count;

   wire sclk_s = sync_b[0];
   wire din_s = sync_b[1];
   wire latch_s = sync_b[2];
   wire load_s = sync_b[3];
   wire temp_s = sync_b[4];
   wire sclk_rise = sclk_s & ~sclk_d;
   wire sclk_fall = ~sclk_s & sclk_d;
   wire latch_rise = latch_s & ~latch_d;
   wire [7:0] frame_cmd = shift_in[23:16];
   wire [15:0] frame_data = shift_in[15:0];

   wire ramp_en = output_control[`CDRB_CTRL_RAMPEN];
   wire [3:0] ramp_clk_sel =
      output_control[`CDRB_CTRL_RCLK_HI:`CDRB_CTRL_RCLK_LO];
   wire [2:0] ramp_step_sel =
      output_control[`CDRB_CTRL_RSTEP_HI:`CDRB_CTRL_RSTEP_LO];
   wire ramp_busy = ramp_en && (ramp_code != target_code);

   wire [15:0] fault_status = {11'h000, frame_error_flag, timeout_flag,
      load_fault_flag, ramp_busy, overtemp_flag};

   // readback selection from the low six data bits of the read frame
   reg [15:0] read_word;
   always @* begin
      read_word = 16'h0000;
      if (read_sel == `CDRB_RD_CONFIG) begin
         read_word = feature_config;
      end else if (read_sel == `CDRB_RD_GAIN) begin
         read_word = keep_code(gain_trim);
      end else if (read_sel == `CDRB_RD_ZERO) begin
         read_word = keep_code(offset_trim);
      end else begin
         case (read_sel[1:0])
            `CDRB_RD_STATUS: read_word = fault_status;
            `CDRB_RD_CODE: read_word = keep_code(output_code);
            `CDRB_RD_CTRL: read_word = output_control;
            default: read_word = 16'h0000;
         endcase
      end
   end

   // trim: gain scales down from unity, offset is signed
   reg [32:0] trim_prod;
   reg [17:0] trim_sum;
   reg [15:0] next_target;
   always @* begin
      trim_prod = output_code * (17'h1_0000 - {1'b0, gain_trim});
      trim_sum = {1'b0, trim_prod[32:16]} +
         {{2{offset_trim[15]}}, offset_trim};
      if (!feature_config[`CDRB_CFG_TRIM]) begin
         next_target = output_code;
      end else if (trim_sum[17]) begin
         next_target = 16'h0000;
      end else if (trim_sum[16]) begin
         next_target = 16'hFFFF;
      end else begin
         next_target = trim_sum[15:0];
      end
   end

   // ramp step toward target without overshoot
   reg [15:0] step;
   reg [15:0] gap;
   reg [15:0] next_ramp;
   always @* begin
      step = 16'h0001 << ramp_step_sel;
      if (target_code > ramp_code) begin
         gap = target_code - ramp_code;
         next_ramp = (gap > step) ? ramp_code + step : target_code;
      end else begin
         gap = ramp_code - target_code;
         next_ramp = (gap > step) ? ramp_code - step : target_code;
      end
   end

   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         sync_a <= 5'h00;
         sync_b <= 5'h00;
         sclk_d <= 1'b0;
         latch_d <= 1'b0;
      end else begin
         sync_a <= {DIE_OVERTEMP, LOAD_FAULT, SERIAL_LATCH, SERIAL_DIN,
            SERIAL_CLK};
         sync_b <= sync_a;
         sclk_d <= sclk_s;
         latch_d <= latch_s;
      end
   end

   // serial shift in and readback shift out
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         shift_in <= 24'h00_0000;
         shift_out <= 24'h00_0000;
         SERIAL_DOUT <= 1'b0;
      end else begin
         if (sclk_rise) begin
            shift_in <= {shift_in[22:0], din_s};
         end
         // load a cycle after the read latch, so the very next frame shifts
         if (read_pending) begin
            shift_out <= {8'h00, read_word};
            SERIAL_DOUT <= 1'b0;
         end else if (latch_rise) begin
            shift_out <= 24'h00_0000;
            SERIAL_DOUT <= 1'b0;
         end else if (sclk_fall) begin
            SERIAL_DOUT <= shift_out[23];
            shift_out <= {shift_out[22:0], 1'b0};
         end
      end
   end

   // register writes, soft reset wins over all
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         output_control <= `CDRB_RST_WORD;
         feature_config <= `CDRB_RST_WORD;
         output_code <= `CDRB_RST_WORD;
         gain_trim <= `CDRB_RST_WORD;
         offset_trim <= `CDRB_RST_WORD;
         read_pending <= 1'b0;
         read_sel <= 6'h00;
         soft_reset <= 1'b0;
         TIMEOUT_SERVICE <= 1'b0;
      end else begin
         TIMEOUT_SERVICE <= 1'b0;
         read_pending <= 1'b0;
         soft_reset <= 1'b0;
         if (soft_reset) begin
            output_control <= `CDRB_RST_WORD;
            feature_config <= `CDRB_RST_WORD;
            output_code <= `CDRB_RST_WORD;
            gain_trim <= `CDRB_RST_WORD;
            offset_trim <= `CDRB_RST_WORD;
            read_pending <= 1'b0;
            read_sel <= 6'h00;
         end else if (latch_rise) begin
            read_pending <= (frame_cmd == `CDRB_CMD_READ);
            case (frame_cmd)
               `CDRB_CMD_CTRL: begin
                  // reserved bits dropped in case host disobeys
                  output_control <= frame_data & `CDRB_CTRL_MASK;
               end
               `CDRB_CMD_CONFIG: begin
                  feature_config <= frame_data & `CDRB_CFG_MASK;
               end
               `CDRB_CMD_CODE: begin
                  output_code <= keep_code(frame_data);
               end
               `CDRB_CMD_GAIN: begin
                  gain_trim <= keep_code(frame_data);
               end
               `CDRB_CMD_ZERO: begin
                  offset_trim <= keep_code(frame_data);
               end
               `CDRB_CMD_RESET: begin
                  soft_reset <= frame_data[0];
               end
               `CDRB_CMD_READ: begin
                  read_sel <= frame_data[5:0];
               end
               `CDRB_CMD_WD_SERVICE: begin
                  TIMEOUT_SERVICE <= 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // fault flags; a new frame or timeout event wins over its clear, soft reset wins over level faults
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         frame_error_flag <= 1'b0;
         timeout_flag <= 1'b0;
         load_fault_flag <= 1'b0;
         overtemp_flag <= 1'b0;
      end else begin
         if (FRAME_CHECK_FAIL && feature_config[`CDRB_CFG_FCHK]) begin
            frame_error_flag <= 1'b1;
         end else if (soft_reset || (latch_rise &&
               frame_cmd == `CDRB_CMD_CRC_CLEAR)) begin
            frame_error_flag <= 1'b0;
         end
         if (TIMEOUT_EXPIRED && feature_config[`CDRB_CFG_TIMEOUT_MONITOR_ENABLE]) begin
            timeout_flag <= 1'b1;
         end else if (soft_reset || (latch_rise &&
               frame_cmd == `CDRB_CMD_WD_SERVICE)) begin
            timeout_flag <= 1'b0;
         end
         // level faults track the monitor, soft reset clears a cycle
         load_fault_flag <= load_s & ~soft_reset;
         overtemp_flag <= temp_s & ~soft_reset;
      end
   end

   // calibrated target and ramp engine
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         target_code <= 16'h0000;
         ramp_code <= 16'h0000;
         ramp_count <= 24'h00_0000;
      end else begin
         target_code <= keep_code(next_target);
         if (!ramp_en) begin
            ramp_code <= target_code;
            ramp_count <= 24'h00_0000;
         end else if (ramp_code == target_code) begin
            ramp_count <= 24'h00_0000;
         end else if (ramp_count >=
               (RAMP_BASE_CYC[23:0] << ramp_clk_sel) - 24'h00_0001) begin
            ramp_count <= 24'h00_0000;
            ramp_code <= next_ramp;
         end else begin
            ramp_count <= ramp_count + 24'h00_0001;
         end
      end
   end

   // output side registers
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         OUTPUT_CODE <= 16'h0000;
         OUTPUT_RANGE <= 3'h0;
         OUTPUT_DRIVE_ENABLE <= 1'b0;
         EXTERNAL_RESISTOR_SELECT <= 1'b0;
         MODEM_COUPLING_ENABLE <= 1'b0;
         FRAME_CHECK_ENABLE <= 1'b0;
         TIMEOUT_MONITOR_ENABLE <= 1'b0;
         TIMEOUT_PERIOD_SELECT <= 2'h0;
         RAMP_ACTIVE_FLAG <= 1'b0;
      end else begin
         OUTPUT_CODE <= ramp_code;
         OUTPUT_RANGE <= output_control[2:0];
         OUTPUT_DRIVE_ENABLE <= output_control[`CDRB_CTRL_OUTPUT_DRIVE_ENABLE];
         EXTERNAL_RESISTOR_SELECT <=
            output_control[`CDRB_CTRL_EXTRES];
         MODEM_COUPLING_ENABLE <= feature_config[`CDRB_CFG_MODEM] &&
            (output_control[2:0] == LOOP_RANGE_CODE);
         FRAME_CHECK_ENABLE <= feature_config[`CDRB_CFG_FCHK];
         TIMEOUT_MONITOR_ENABLE <= feature_config[`CDRB_CFG_TIMEOUT_MONITOR_ENABLE];
         TIMEOUT_PERIOD_SELECT <= feature_config[1:0];
         RAMP_ACTIVE_FLAG <= ramp_busy;
      end
   end

endmodule
